/* File: hdl/sdram_bank_timing_pkg.sv */
// constants, types and decode functions for the bank 1 timing registers
package sdram_bank_timing_pkg;

  typedef logic [7:0]  byte_type;
  typedef logic [31:0] word_type;
  typedef logic [7:0]  cfg_addr_type;
  typedef logic [7:0]  cycles_type;
  typedef logic signed [7:0] tenths_type;

  // configuration space offsets
  localparam cfg_addr_type ROW_STROBE_TIMING_OFFSET  = 8'hCC;
  localparam cfg_addr_type INPUT_SETUP_HOLD_OFFSET   = 8'hD0;
  localparam cfg_addr_type PRESENCE_DETECT_OFFSET    = 8'hEC;
  localparam cfg_addr_type AUXILIARY_TIMING_OFFSET   = 8'hF0;

  // field positions (low bit of each byte field)
  localparam int ROW_ACTIVE_MIN_WIDTH_LSB = 16;
  localparam int ROW_TO_COLUMN_DELAY_LSB  = 8;
  localparam int DATA_INPUT_HOLD_LSB      = 24;
  localparam int DATA_INPUT_SETUP_LSB     = 16;
  localparam int ADDR_CMD_HOLD_LSB        = 8;
  localparam int ADDR_CMD_SETUP_LSB       = 0;
  localparam int PRESENCE_DETECT_LSB      = 16;
  localparam int WRITE_RECOVERY_LSB       = 24;
  localparam int MODE_WRITE_RECOVERY_LSB  = 16;
  localparam int SELF_REFRESH_EXIT_LSB    = 8;
  localparam int REFRESH_CYCLE_LSB        = 0;
  localparam int PBCD_SIGN_BIT            = 7;
  localparam int REVISION_TAG_WIDTH       = 2;

  // writable bits; the rest read as zero
  localparam word_type ROW_STROBE_WRITE_MASK    = 32'h00FF_FF00;
  localparam word_type INPUT_SETUP_WRITE_MASK   = 32'hFFFF_FFFF;
  localparam word_type PRESENCE_WRITE_MASK      = 32'h0003_0000;
  localparam word_type AUXILIARY_WRITE_MASK     = 32'hFFFF_FFFF;

  // reset values
  localparam word_type ROW_STROBE_RESET         = 32'h0000_0000;
  localparam word_type INPUT_SETUP_RESET        = 32'h0000_0000;
  localparam word_type PRESENCE_RESET           = 32'h0000_0000;
  localparam word_type AUXILIARY_RESET          = 32'h8080_5046;

  // lowest revision tag whose configuration is acted on is this plus one
  localparam logic [1:0] REVISION_THRESHOLD     = 2'h1;

  // timing: clock period and derived units
  localparam int CLK_PERIOD_NS        = 10;
  localparam int EIGHTHS_PER_NS       = 8;
  localparam int EIGHTHS_PER_CYCLE    = CLK_PERIOD_NS * EIGHTHS_PER_NS;
  localparam int TENTHS_PER_NS        = 10;

  // rounded-up division of a byte by a unit size
  function automatic cycles_type ceil_div(input byte_type value, input int unit);
    int q;
    q = (int'(value) + unit - 1) / unit;
    return cycles_type'(q);
  endfunction

  function automatic cycles_type ns_to_cycles(input byte_type ns);
    return ceil_div(ns, CLK_PERIOD_NS);
  endfunction

  function automatic cycles_type eighths_to_cycles(input byte_type eighths);
    return ceil_div(eighths, EIGHTHS_PER_CYCLE);
  endfunction

  // sign bit, then whole ns in bits 6:4 and tenths in bits 3:0
  function automatic tenths_type pbcd_to_tenths(input byte_type code);
    int mag;
    mag = int'(code[6:4]) * TENTHS_PER_NS + int'(code[3:0]);
    if (code[PBCD_SIGN_BIT]) begin
      mag = -mag;
    end
    return tenths_type'(mag);
  endfunction

  // applied cycle counts while no configuration has been accepted
  localparam cycles_type WRITE_RECOVERY_CYCLES_RESET =
    eighths_to_cycles(AUXILIARY_RESET[WRITE_RECOVERY_LSB +: 8]);
  localparam cycles_type MODE_WRITE_RECOVERY_CYCLES_RESET =
    eighths_to_cycles(AUXILIARY_RESET[MODE_WRITE_RECOVERY_LSB +: 8]);
  localparam cycles_type SELF_REFRESH_EXIT_CYCLES_RESET =
    ns_to_cycles(AUXILIARY_RESET[SELF_REFRESH_EXIT_LSB +: 8]);
  localparam cycles_type REFRESH_CYCLE_CYCLES_RESET =
    ns_to_cycles(AUXILIARY_RESET[REFRESH_CYCLE_LSB +: 8]);
  localparam cycles_type ZERO_CYCLES = 8'h00;
  localparam tenths_type ZERO_TENTHS = 8'sh00;

endpackage

/* File: hdl/timing_link_if.sv */
// raw programmed fields and their converted forms, between bank and converter
`timescale 1ns/1ns
interface timing_link_if;
  import sdram_bank_timing_pkg::*;
  byte_type   row_active_min_width;
  byte_type   row_to_column_delay;
  byte_type   write_recovery_time;
  byte_type   mode_write_recovery_time;
  byte_type   self_refresh_exit_latency;
  byte_type   refresh_cycle_time;
  byte_type   data_input_hold;
  byte_type   data_input_setup;
  byte_type   addr_cmd_hold;
  byte_type   addr_cmd_setup;
  cycles_type row_active_cycles;
  cycles_type row_to_column_cycles;
  cycles_type write_recovery_cycles;
  cycles_type mode_write_recovery_cycles;
  cycles_type self_refresh_exit_cycles;
  cycles_type refresh_cycle_cycles;
  tenths_type data_hold_tenths;
  tenths_type data_setup_tenths;
  tenths_type addr_hold_tenths;
  tenths_type addr_setup_tenths;

  modport source (
    output row_active_min_width, row_to_column_delay, write_recovery_time,
           mode_write_recovery_time, self_refresh_exit_latency, refresh_cycle_time,
           data_input_hold, data_input_setup, addr_cmd_hold, addr_cmd_setup,
    input  row_active_cycles, row_to_column_cycles, write_recovery_cycles,
           mode_write_recovery_cycles, self_refresh_exit_cycles, refresh_cycle_cycles,
           data_hold_tenths, data_setup_tenths, addr_hold_tenths, addr_setup_tenths
  );
  modport converter (
    input  row_active_min_width, row_to_column_delay, write_recovery_time,
           mode_write_recovery_time, self_refresh_exit_latency, refresh_cycle_time,
           data_input_hold, data_input_setup, addr_cmd_hold, addr_cmd_setup,
    output row_active_cycles, row_to_column_cycles, write_recovery_cycles,
           mode_write_recovery_cycles, self_refresh_exit_cycles, refresh_cycle_cycles,
           data_hold_tenths, data_setup_tenths, addr_hold_tenths, addr_setup_tenths
  );
endinterface

/* File: hdl/timing_converter.sv */
// converts programmed ns, eighth-ns and pseudo-BCD fields into usable forms
`timescale 1ns/1ns
module timing_converter (
  timing_link_if.converter link
);
  import sdram_bank_timing_pkg::*;

  // rounding up keeps every programmed minimum at least as long
  assign link.row_active_cycles          = ns_to_cycles(link.row_active_min_width);
  assign link.row_to_column_cycles       = ns_to_cycles(link.row_to_column_delay);
  assign link.write_recovery_cycles      = eighths_to_cycles(link.write_recovery_time);
  assign link.mode_write_recovery_cycles = eighths_to_cycles(link.mode_write_recovery_time);
  assign link.self_refresh_exit_cycles   = ns_to_cycles(link.self_refresh_exit_latency);
  assign link.refresh_cycle_cycles       = ns_to_cycles(link.refresh_cycle_time);
  assign link.data_hold_tenths           = pbcd_to_tenths(link.data_input_hold);
  assign link.data_setup_tenths          = pbcd_to_tenths(link.data_input_setup);
  assign link.addr_hold_tenths           = pbcd_to_tenths(link.addr_cmd_hold);
  assign link.addr_setup_tenths          = pbcd_to_tenths(link.addr_cmd_setup);
endmodule

/* File: hdl/sdram_bank_timing_registers.sv */
// bank 1 timing parameter registers with configuration space access
//
// Summary of operation
// - row-active minimum width in bits 23:16
// - row-to-column delay in bits 15:8
// - data hold 31:24, data setup 23:16
// - address/command hold 15:8, setup 7:0
// - setup/hold bytes signed by bit 7
// - magnitude pseudo-BCD: whole ns, tenths
// - revision tag bits 23:16, two low bits
// - act only when revision tag exceeds one
// - write recovery eighth-ns in 31:24
// - mode write recovery eighth-ns in 23:16
// - self-refresh exit ns in 15:8
// - refresh cycle ns in 7:0
// - auxiliary reset 80805046h, others zero, RW
`timescale 1ns/1ns
module sdram_bank_timing_registers (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                nrst,
  // configuration space access
  input  wire sdram_bank_timing_pkg::cfg_addr_type cfg_addr,
  input  wire logic                                cfg_wr_en,
  input  wire logic                                cfg_rd_en,
  input  wire logic [3:0]                          cfg_byte_en,
  input  wire sdram_bank_timing_pkg::word_type     cfg_wdata,
  output      sdram_bank_timing_pkg::word_type     cfg_rdata,
  output      logic                                cfg_rd_valid,
  // applied timing toward the command sequencer
  output      logic                                config_accepted,
  output      sdram_bank_timing_pkg::cycles_type   row_active_min_cycles,
  output      sdram_bank_timing_pkg::cycles_type   row_to_column_cycles,
  output      sdram_bank_timing_pkg::cycles_type   write_recovery_cycles,
  output      sdram_bank_timing_pkg::cycles_type   mode_write_recovery_cycles,
  output      sdram_bank_timing_pkg::cycles_type   self_refresh_exit_cycles,
  output      sdram_bank_timing_pkg::cycles_type   refresh_cycle_cycles,
  // applied setup and hold, signed tenths of ns
  output      sdram_bank_timing_pkg::tenths_type   data_input_hold,
  output      sdram_bank_timing_pkg::tenths_type   data_input_setup,
  output      sdram_bank_timing_pkg::tenths_type   addr_cmd_hold,
  output      sdram_bank_timing_pkg::tenths_type   addr_cmd_setup
);
  import sdram_bank_timing_pkg::*;

  // byte-lane merge, limited to implemented bits
  function automatic word_type merge_write(input word_type old_value, input word_type data,
                                           input logic [3:0] lanes, input word_type mask);
    word_type lane_mask;
    lane_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}} & mask;
    return (old_value & ~lane_mask) | (data & lane_mask);
  endfunction

  word_type bank1_row_strobe_timing;
  word_type bank1_input_setup_hold_timing;
  word_type bank1_presence_detect_revision;
  word_type bank1_auxiliary_timing_one;

  wire logic hit_row_strobe = (cfg_addr == ROW_STROBE_TIMING_OFFSET);
  wire logic hit_setup_hold = (cfg_addr == INPUT_SETUP_HOLD_OFFSET);
  wire logic hit_presence   = (cfg_addr == PRESENCE_DETECT_OFFSET);
  wire logic hit_auxiliary  = (cfg_addr == AUXILIARY_TIMING_OFFSET);

  // unmapped offsets read zero and swallow writes
  wire word_type read_select =
    hit_row_strobe ? bank1_row_strobe_timing :
    hit_setup_hold ? bank1_input_setup_hold_timing :
    hit_presence   ? bank1_presence_detect_revision :
    hit_auxiliary  ? bank1_auxiliary_timing_one :
                     32'h0000_0000;

  // one write strobe per register, decoded from the shared offset
  wire logic write_row_strobe = cfg_wr_en && hit_row_strobe;
  wire logic write_setup_hold = cfg_wr_en && hit_setup_hold;
  wire logic write_presence   = cfg_wr_en && hit_presence;
  wire logic write_auxiliary  = cfg_wr_en && hit_auxiliary;

  // a register not addressed keeps its value; no lanes enabled is no change
  wire word_type next_row_strobe = write_row_strobe ?
    merge_write(bank1_row_strobe_timing, cfg_wdata, cfg_byte_en, ROW_STROBE_WRITE_MASK) :
    bank1_row_strobe_timing;
  wire word_type next_setup_hold = write_setup_hold ?
    merge_write(bank1_input_setup_hold_timing, cfg_wdata, cfg_byte_en, INPUT_SETUP_WRITE_MASK) :
    bank1_input_setup_hold_timing;
  // upper six bits of the tag are held at zero
  wire word_type next_presence = write_presence ?
    merge_write(bank1_presence_detect_revision, cfg_wdata, cfg_byte_en, PRESENCE_WRITE_MASK) :
    bank1_presence_detect_revision;
  wire word_type next_auxiliary = write_auxiliary ?
    merge_write(bank1_auxiliary_timing_one, cfg_wdata, cfg_byte_en, AUXILIARY_WRITE_MASK) :
    bank1_auxiliary_timing_one;
  // zero unless a read was asked for, so stale data never lingers on the bus
  wire word_type next_rdata = cfg_rd_en ? read_select : 32'h0000_0000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank1_row_strobe_timing <= ROW_STROBE_RESET;
    end else begin
      bank1_row_strobe_timing <= next_row_strobe;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank1_input_setup_hold_timing <= INPUT_SETUP_RESET;
    end else begin
      bank1_input_setup_hold_timing <= next_setup_hold;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank1_presence_detect_revision <= PRESENCE_RESET;
    end else begin
      bank1_presence_detect_revision <= next_presence;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank1_auxiliary_timing_one <= AUXILIARY_RESET;
    end else begin
      bank1_auxiliary_timing_one <= next_auxiliary;
    end
  end

  // read data one cycle after the request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata    <= 32'h0000_0000;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rdata    <= next_rdata;
      cfg_rd_valid <= cfg_rd_en;
    end
  end

  timing_link_if link ();

  assign link.row_active_min_width      = bank1_row_strobe_timing[ROW_ACTIVE_MIN_WIDTH_LSB +: 8];
  assign link.row_to_column_delay       = bank1_row_strobe_timing[ROW_TO_COLUMN_DELAY_LSB +: 8];
  assign link.data_input_hold           = bank1_input_setup_hold_timing[DATA_INPUT_HOLD_LSB +: 8];
  assign link.data_input_setup          = bank1_input_setup_hold_timing[DATA_INPUT_SETUP_LSB +: 8];
  assign link.addr_cmd_hold             = bank1_input_setup_hold_timing[ADDR_CMD_HOLD_LSB +: 8];
  assign link.addr_cmd_setup            = bank1_input_setup_hold_timing[ADDR_CMD_SETUP_LSB +: 8];
  assign link.write_recovery_time       = bank1_auxiliary_timing_one[WRITE_RECOVERY_LSB +: 8];
  assign link.mode_write_recovery_time  = bank1_auxiliary_timing_one[MODE_WRITE_RECOVERY_LSB +: 8];
  assign link.self_refresh_exit_latency = bank1_auxiliary_timing_one[SELF_REFRESH_EXIT_LSB +: 8];
  assign link.refresh_cycle_time        = bank1_auxiliary_timing_one[REFRESH_CYCLE_LSB +: 8];

  timing_converter converter (
    .link (link.converter)
  );

  wire logic [1:0] revision_tag =
    bank1_presence_detect_revision[PRESENCE_DETECT_LSB +: REVISION_TAG_WIDTH];
  wire logic revision_ok = (revision_tag > REVISION_THRESHOLD);

  // applied values freeze while the tag is too old, so a half-written
  // configuration under an old tag never reaches the sequencer
  wire cycles_type next_row_active_min_cycles =
    revision_ok ? link.row_active_cycles : row_active_min_cycles;
  wire cycles_type next_row_to_column_cycles =
    revision_ok ? link.row_to_column_cycles : row_to_column_cycles;
  wire cycles_type next_write_recovery_cycles =
    revision_ok ? link.write_recovery_cycles : write_recovery_cycles;
  wire cycles_type next_mode_write_recovery_cycles =
    revision_ok ? link.mode_write_recovery_cycles : mode_write_recovery_cycles;
  wire cycles_type next_self_refresh_exit_cycles =
    revision_ok ? link.self_refresh_exit_cycles : self_refresh_exit_cycles;
  wire cycles_type next_refresh_cycle_cycles =
    revision_ok ? link.refresh_cycle_cycles : refresh_cycle_cycles;
  wire tenths_type next_data_input_hold =
    revision_ok ? link.data_hold_tenths : data_input_hold;
  wire tenths_type next_data_input_setup =
    revision_ok ? link.data_setup_tenths : data_input_setup;
  wire tenths_type next_addr_cmd_hold =
    revision_ok ? link.addr_hold_tenths : addr_cmd_hold;
  wire tenths_type next_addr_cmd_setup =
    revision_ok ? link.addr_setup_tenths : addr_cmd_setup;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      config_accepted <= 1'b0;
    end else begin
      config_accepted <= revision_ok;
    end
  end

  // reset values stand until the first configuration is accepted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      row_active_min_cycles <= ZERO_CYCLES;
      row_to_column_cycles  <= ZERO_CYCLES;
    end else begin
      row_active_min_cycles <= next_row_active_min_cycles;
      row_to_column_cycles  <= next_row_to_column_cycles;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_recovery_cycles      <= WRITE_RECOVERY_CYCLES_RESET;
      mode_write_recovery_cycles <= MODE_WRITE_RECOVERY_CYCLES_RESET;
      self_refresh_exit_cycles   <= SELF_REFRESH_EXIT_CYCLES_RESET;
      refresh_cycle_cycles       <= REFRESH_CYCLE_CYCLES_RESET;
    end else begin
      write_recovery_cycles      <= next_write_recovery_cycles;
      mode_write_recovery_cycles <= next_mode_write_recovery_cycles;
      self_refresh_exit_cycles   <= next_self_refresh_exit_cycles;
      refresh_cycle_cycles       <= next_refresh_cycle_cycles;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_input_hold  <= ZERO_TENTHS;
      data_input_setup <= ZERO_TENTHS;
      addr_cmd_hold    <= ZERO_TENTHS;
      addr_cmd_setup   <= ZERO_TENTHS;
    end else begin
      data_input_hold  <= next_data_input_hold;
      data_input_setup <= next_data_input_setup;
      addr_cmd_hold    <= next_addr_cmd_hold;
      addr_cmd_setup   <= next_addr_cmd_setup;
    end
  end

endmodule

/* File: tb/sdram_bank_timing_registers_props.sv */
// port assertions for the bank 1 timing registers
`timescale 1ns/1ns
module sdram_bank_timing_registers_props (
  // clock and reset
  input wire logic                                clk,
  input wire logic                                nrst,
  // configuration access
  input wire sdram_bank_timing_pkg::cfg_addr_type cfg_addr,
  input wire logic                                cfg_wr_en,
  input wire logic                                cfg_rd_en,
  input wire logic [3:0]                          cfg_byte_en,
  input wire sdram_bank_timing_pkg::word_type     cfg_wdata,
  input wire sdram_bank_timing_pkg::word_type     cfg_rdata,
  input wire logic                                cfg_rd_valid,
  // applied timing
  input wire logic                                config_accepted,
  input wire sdram_bank_timing_pkg::cycles_type   row_active_min_cycles,
  input wire sdram_bank_timing_pkg::cycles_type   write_recovery_cycles,
  input wire sdram_bank_timing_pkg::cycles_type   self_refresh_exit_cycles,
  input wire sdram_bank_timing_pkg::cycles_type   refresh_cycle_cycles,
  input wire sdram_bank_timing_pkg::tenths_type   data_input_setup
);
  import sdram_bank_timing_pkg::*;
  wire logic mapped = cfg_addr inside {ROW_STROBE_TIMING_OFFSET, INPUT_SETUP_HOLD_OFFSET,
                                       PRESENCE_DETECT_OFFSET, AUXILIARY_TIMING_OFFSET};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence tag_write;
    cfg_wr_en && cfg_addr == PRESENCE_DETECT_OFFSET && cfg_byte_en[2];
  endsequence
  sequence aux_write_then_read;
    cfg_wr_en && cfg_addr == AUXILIARY_TIMING_OFFSET && cfg_byte_en == 4'hF
    ##1 cfg_rd_en && !cfg_wr_en && cfg_addr == AUXILIARY_TIMING_OFFSET;
  endsequence
  AST_RD_VALID: assert property (cfg_rd_en |=> cfg_rd_valid)
    else $error("read not answered next cycle");
  AST_RD_IDLE: assert property (!cfg_rd_en |=> !cfg_rd_valid && cfg_rdata == 32'h0000_0000)
    else $error("read data without a read");
  AST_UNMAPPED: assert property (cfg_rd_en && !mapped |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_ROW_RESERVED: assert property (cfg_rd_en && cfg_addr == ROW_STROBE_TIMING_OFFSET
    |=> (cfg_rdata & ~ROW_STROBE_WRITE_MASK) == 32'h0000_0000) else $error("row strobe reserved bits set");
  AST_REV_RESERVED: assert property (cfg_rd_en && cfg_addr == PRESENCE_DETECT_OFFSET
    |=> (cfg_rdata & ~PRESENCE_WRITE_MASK) == 32'h0000_0000) else $error("revision reserved bits set");
  AST_AUX_READBACK: assert property (aux_write_then_read |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("auxiliary readback differs");
  AST_ACCEPT: assert property (tag_write ##0 (cfg_wdata[17:16] > 2'h1) |-> ##2 config_accepted)
    else $error("good revision not accepted");
  AST_REJECT: assert property (tag_write ##0 (cfg_wdata[17:16] <= 2'h1) |-> ##2 !config_accepted)
    else $error("low revision accepted");
  AST_FROZEN: assert property (!config_accepted |-> $stable(row_active_min_cycles)
    && $stable(write_recovery_cycles) && $stable(data_input_setup)) else $error("outputs moved while ignored");
  AST_RESET_APPLIED: assert property ($rose(nrst) |-> !config_accepted && write_recovery_cycles == 8'h02
    && self_refresh_exit_cycles == 8'h08 && refresh_cycle_cycles == 8'h07) else $error("bad applied reset");
endmodule
bind sdram_bank_timing_registers sdram_bank_timing_registers_props i_props (.clk, .nrst, .cfg_addr,
  .cfg_wr_en, .cfg_rd_en, .cfg_byte_en, .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .config_accepted,
  .row_active_min_cycles, .write_recovery_cycles, .self_refresh_exit_cycles, .refresh_cycle_cycles,
  .data_input_setup);

/* File: tb/test_sdram_bank_timing_registers.sv */
// self-checking bench for the bank 1 timing registers
`timescale 1ns/1ns
module test_sdram_bank_timing_registers;
  import sdram_bank_timing_pkg::*;
  localparam cfg_addr_type ADDRS [4] = '{ROW_STROBE_TIMING_OFFSET, INPUT_SETUP_HOLD_OFFSET,
                                        PRESENCE_DETECT_OFFSET, AUXILIARY_TIMING_OFFSET};
  localparam word_type MASKS [4] = '{ROW_STROBE_WRITE_MASK, INPUT_SETUP_WRITE_MASK,
                                     PRESENCE_WRITE_MASK, AUXILIARY_WRITE_MASK};
  localparam word_type RESETS [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h8080_5046};
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  cfg_addr_type cfg_addr = 8'h00;
  logic         cfg_wr_en = 1'b0;
  logic         cfg_rd_en = 1'b0;
  logic [3:0]   cfg_byte_en = 4'h0;
  word_type     cfg_wdata = 32'h0000_0000;
  word_type     cfg_rdata;
  logic         cfg_rd_valid;
  logic         config_accepted;
  cycles_type   row_active_min_cycles, row_to_column_cycles, write_recovery_cycles;
  cycles_type   mode_write_recovery_cycles, self_refresh_exit_cycles, refresh_cycle_cycles;
  tenths_type   data_input_hold, data_input_setup, addr_cmd_hold, addr_cmd_setup;
  word_type     model [4];
  word_type     live [4];
  word_type     expq [$];
  logic         acc_exp = 1'b0;
  logic [31:0]  lfsr = 32'h3BB1;
  int           mismatches = 0;
  int           checks_done = 0;
  always #5 clk = ~clk;
  sdram_bank_timing_registers i_dut (.clk, .nrst, .cfg_addr, .cfg_wr_en, .cfg_rd_en, .cfg_byte_en, .cfg_wdata,
    .cfg_rdata, .cfg_rd_valid, .config_accepted, .row_active_min_cycles, .row_to_column_cycles,
    .write_recovery_cycles, .mode_write_recovery_cycles, .self_refresh_exit_cycles, .refresh_cycle_cycles,
    .data_input_hold, .data_input_setup, .addr_cmd_hold, .addr_cmd_setup);
  function automatic word_type next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // rounding up so a programmed minimum is never shortened
  function automatic cycles_type up(byte_type v, int unit);
    return cycles_type'((int'(v) + unit - 1) / unit);
  endfunction
  function automatic tenths_type pbcd(byte_type b);
    int mag;
    mag = int'(b[6:4]) * 10 + int'(b[3:0]);
    return tenths_type'(b[7] ? -mag : mag);
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    check("reads answered", 32'(expq.size()), 32'h0);
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // strobes stay up between calls so transfers run back to back
  task automatic reg_write(int i, word_type d, logic [3:0] be);
    cfg_addr <= ADDRS[i];
    cfg_wr_en <= 1'b1;
    cfg_rd_en <= 1'b0;
    cfg_byte_en <= be;
    cfg_wdata <= d;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) model[i][8*b +: 8] = d[8*b +: 8] & MASKS[i][8*b +: 8];
    end
    if (i == 2 && be[2]) acc_exp = model[2][17:16] > 2'h1;
    @(posedge clk);
  endtask
  task automatic reg_read(cfg_addr_type a, word_type exp);
    cfg_addr <= a;
    cfg_rd_en <= 1'b1;
    cfg_wr_en <= 1'b0;
    expq.push_back(exp);
    @(posedge clk);
  endtask
  task automatic read_all();
    for (int i = 0; i < 4; i++) reg_read(ADDRS[i], model[i]);
  endtask
  task automatic chk_applied();
    check("accepted", 32'(config_accepted), 32'(acc_exp));
    check("row active", row_active_min_cycles, up(live[0][23:16], 10));
    check("row to column", row_to_column_cycles, up(live[0][15:8], 10));
    check("data hold", data_input_hold, pbcd(live[1][31:24]));
    check("data setup", data_input_setup, pbcd(live[1][23:16]));
    check("addr hold", addr_cmd_hold, pbcd(live[1][15:8]));
    check("addr setup", addr_cmd_setup, pbcd(live[1][7:0]));
    check("write recovery", write_recovery_cycles, up(live[3][31:24], 80));
    check("mode recovery", mode_write_recovery_cycles, up(live[3][23:16], 80));
    check("self refresh exit", self_refresh_exit_cycles, up(live[3][15:8], 10));
    check("refresh cycle", refresh_cycle_cycles, up(live[3][7:0], 10));
  endtask
  // applied values lag the registers by one cycle
  task automatic settle();
    cfg_wr_en <= 1'b0;
    cfg_rd_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    if (acc_exp) live = model;
    chk_applied();
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (nrst === 1'b1 && cfg_rd_valid === 1'b1) begin
      if (expq.size() > 0) begin
        check("cfg_rdata", cfg_rdata, expq.pop_front());
      end else begin
        check("read count", 32'h1, 32'h0);
      end
    end
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    word_type d;
    word_type r;
    model = RESETS;
    live = RESETS;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    read_all();
    reg_read(8'hF4, 32'h0000_0000);
    reg_write(2, 32'hFFFD_FFFF, 4'hF);
    reg_write(0, 32'hAA29_2855, 4'hF);
    reg_write(1, 32'hF979_8015, 4'hF);
    reg_write(3, 32'h5150_0100, 4'hF);
    reg_read(ADDRS[3], model[3]);
    reg_write(0, 32'hFFFF_FFFF, 4'h0);
    // unmapped offset next to the auxiliary register must swallow the write
    cfg_addr <= 8'hF4;
    cfg_byte_en <= 4'hF;
    cfg_wdata <= 32'hFFFF_FFFF;
    @(posedge clk);
    read_all();
    settle();
    for (int k = 0; k < 8; k++) begin
      d = next_rand();
      d[17:16] = 2'(k);
      reg_write(2, d, 4'hF);
      for (int i = 0; i < 4; i++) begin
        r = next_rand();
        if (i != 2) reg_write(i, next_rand(), r[3:0]);
      end
      read_all();
      settle();
    end
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    model = RESETS;
    live = RESETS;
    acc_exp = 1'b0;
    nrst <= 1'b1;
    read_all();
    settle();
    conclude();
  end
endmodule
